// ---- dic_top.sv ----
// Top of the digital input conditioner: scan, polarity, delays, stage outputs.
//
// Contract
// - Sample every input once per 5 ms.
// - Polarity per input: NO reports energized high.
// - Activation delay in 1 ms steps, default 0.
// - Drop-off delay in 1 ms steps, default 0.
// - AC mode adds fixed 30 ms drop-off.
// - Logic stage acts one scan later.
// - Direct output stage one more scan later.
`timescale 1ns/1ps
`default_nettype none
module dic_top
    import dic_pkg::*;
#(
    // Clocks per millisecond step. Only a bench shortens it, to keep runs short.
    parameter int unsigned TICK_CYC = STEP_CYC
)
(
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    // Isolated input pins, one per binary_input_n
    input  wire logic [NUM_IN-1:0]          i_binary_input_n,
    // Settings written by software
    input  wire logic [NUM_IN-1:0]          i_polarity_nc,
    input  wire logic [NUM_IN-1:0]          i_ac_mode,
    input  wire logic [NUM_IN*DLY_W-1:0]    i_act_delay_ms,
    input  wire logic [NUM_IN*DLY_W-1:0]    i_drop_delay_ms,
    // Conditioned status for the consumers
    output logic      [NUM_IN-1:0]          o_raw_state,
    output logic      [NUM_IN-1:0]          o_status,
    output logic      [NUM_IN-1:0]          o_logic_state,
    output logic      [NUM_IN-1:0]          o_binary_output_n,
    output logic                            o_scan_tick
);

    // ****************************************************************
    // Pin synchronisers and timebase
    // ****************************************************************

    logic [NUM_IN-1:0] sync1_ff;
    logic [NUM_IN-1:0] sync2_ff;
    logic [15:0]       ms_cnt_ff;
    logic              ms_tick_ff;
    logic [2:0]        step_ff;
    logic              scan_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= i_binary_input_n;
            sync2_ff <= sync1_ff;
        end
    end

    // The scan tick is built from whole millisecond steps, so delay counts
    // and scan rounds never drift against each other.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ms_cnt_ff  <= '0;
            ms_tick_ff <= 1'b0;
            step_ff    <= '0;
            scan_ff    <= 1'b0;
        end
        else
        begin
            ms_tick_ff <= 1'b0;
            scan_ff    <= 1'b0;
            if (ms_cnt_ff == 16'(TICK_CYC - 1))
            begin
                ms_cnt_ff  <= '0;
                ms_tick_ff <= 1'b1;
                if (step_ff == 3'(STEPS_PER_SCAN - 1))
                begin
                    step_ff <= '0;
                    scan_ff <= 1'b1;
                end
                else
                begin
                    step_ff <= step_ff + 3'h1;
                end
            end
            else
            begin
                ms_cnt_ff <= ms_cnt_ff + 16'h1;
            end
        end
    end

    // ****************************************************************
    // Scan sampling and polarity
    // ****************************************************************

    logic [NUM_IN-1:0] raw_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            raw_ff <= '0;
        end
        else if (scan_ff)
        begin
            raw_ff <= sync2_ff ^ i_polarity_nc;
        end
    end

    // ****************************************************************
    // Per-input delay channels
    // ****************************************************************

    logic [NUM_IN-1:0] chan_status;

    for (genvar g = 0; g < NUM_IN; g++)
    begin : g_chan
        dic_chan_if cif ();
        assign cif.raw     = raw_ff[g];
        assign cif.ms_tick = ms_tick_ff;
        assign cif.on_dly  = i_act_delay_ms[g*DLY_W +: DLY_W];
        assign cif.off_dly = i_ac_mode[g]
                           ? dic_clip(i_drop_delay_ms[g*DLY_W +: DLY_W], DLY_W'(AC_DELAY_MS))
                           : i_drop_delay_ms[g*DLY_W +: DLY_W];
        assign chan_status[g] = cif.status;
        dic_chan u_chan (
            .i_clk_sys (i_clk_sys),
            .i_rst_n   (i_rst_n),
            .ch        (cif.chan)
        );
    end

    // ****************************************************************
    // Consumer stages
    // ****************************************************************

    logic [NUM_IN-1:0] status_ff;
    logic [NUM_IN-1:0] logic_ff;
    logic [NUM_IN-1:0] out_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_ff <= '0;
        end
        else if (scan_ff)
        begin
            status_ff <= chan_status;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            logic_ff <= '0;
            out_ff   <= '0;
        end
        else if (scan_ff)
        begin
            logic_ff <= status_ff;
            out_ff   <= logic_ff;
        end
    end

    assign o_raw_state       = raw_ff;
    assign o_status          = status_ff;
    assign o_logic_state     = logic_ff;
    assign o_binary_output_n = out_ff;
    assign o_scan_tick       = scan_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************

    a_raw_on_scan: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !scan_ff |=> $stable(raw_ff))
        else $error("raw state changed outside a scan");

    a_polarity_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        scan_ff |=> raw_ff == $past(sync2_ff ^ i_polarity_nc))
        else $error("raw state ignores polarity");

    a_logic_stage: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        scan_ff |=> logic_ff == $past(status_ff))
        else $error("logic stage not one scan behind");

    a_output_stage: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        scan_ff |=> out_ff == $past(logic_ff))
        else $error("output stage not one scan behind");

    a_ac_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ac_mode[0] && i_drop_delay_ms[DLY_W-1:0] == DLY_RST)
        |-> g_chan[0].cif.off_dly == DLY_W'(AC_DELAY_MS))
        else $error("AC mode did not add the fixed drop-off");

    a_scan_period: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        scan_ff |=> !scan_ff [*8])
        else $error("scan ticks too close");

    c_scan: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) scan_ff);
    c_status_rise: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(status_ff[0]));
    c_output_fall: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(out_ff[0]));

endmodule
`default_nettype wire

// ---- dic_pkg.sv ----
// Package of constants and types for the digital input conditioner.
package dic_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned NUM_IN          = 8;
    localparam int unsigned SCAN_TIME_US    = 5000;
    localparam int unsigned SCAN_CYC        = (CLK_HZ / 1_000_000) * SCAN_TIME_US;
    localparam int unsigned STEP_TIME_US    = 1000;
    localparam int unsigned STEP_CYC        = (CLK_HZ / 1_000_000) * STEP_TIME_US;
    localparam int unsigned MAX_DELAY_MS    = 1_800_000;
    localparam int unsigned AC_DELAY_MS     = 30;
    localparam int unsigned DLY_W           = 21;
    localparam int unsigned STEPS_PER_SCAN  = SCAN_TIME_US / STEP_TIME_US;
    localparam logic [DLY_W-1:0] DLY_RST    = 21'h000000;
    localparam logic        POL_NO          = 1'b0;
    localparam logic        POL_RST         = POL_NO;
    localparam logic        AC_RST          = 1'b0;

    typedef logic [DLY_W-1:0] dic_dly_t;

    // Saturating add of a millisecond delay, bounded at the largest setting plus the fixed AC drop-off.
    function automatic dic_dly_t dic_clip(input dic_dly_t a, input dic_dly_t b);
        logic [DLY_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s > (DLY_W+1)'(MAX_DELAY_MS + AC_DELAY_MS))
            dic_clip = DLY_W'(MAX_DELAY_MS + AC_DELAY_MS);
        else
            dic_clip = s[DLY_W-1:0];
    endfunction

endpackage

// ---- dic_chan_if.sv ----
// Interface carrying one input channel's settings and timed status.
`timescale 1ns/1ps
`default_nettype none
interface dic_chan_if;
    import dic_pkg::*;
    logic     raw;
    logic     ms_tick;
    dic_dly_t on_dly;
    dic_dly_t off_dly;
    logic     status;
    modport top  (output raw, ms_tick, on_dly, off_dly, input status);
    modport chan (input raw, ms_tick, on_dly, off_dly, output status);
endinterface
`default_nettype wire

// ---- dic_chan.sv ----
// One channel: pick-up and drop-off timing of a polarised sampled input.
`timescale 1ns/1ps
`default_nettype none
module dic_chan
    import dic_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // Channel carrier
    dic_chan_if.chan  ch
);

    logic     status_ff;
    dic_dly_t cnt_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_ff <= 1'b0;
            cnt_ff    <= DLY_RST;
        end
        else if (ch.raw == status_ff)
        begin
            cnt_ff <= DLY_RST;
        end
        else if (cnt_ff >= (status_ff ? ch.off_dly : ch.on_dly))
        begin
            status_ff <= ch.raw;
            cnt_ff    <= DLY_RST;
        end
        else if (ch.ms_tick)
        begin
            cnt_ff <= cnt_ff + DLY_W'(1);
        end
    end

    assign ch.status = status_ff;

    a_bounce_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ch.raw == status_ff) |=> $stable(status_ff))
        else $error("status changed while raw agreed with it");

    a_zero_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!status_ff && ch.raw && ch.on_dly == DLY_RST) |=> status_ff)
        else $error("zero activation delay did not pass at once");

    a_zero_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (status_ff && !ch.raw && ch.off_dly == DLY_RST) |=> !status_ff)
        else $error("zero drop-off delay did not pass at once");

endmodule
`default_nettype wire

// ---- dic_contacts.sv ----
// Partner model of the external contacts wired to the isolated inputs.
`timescale 1ns/1ps
`default_nettype none
module dic_contacts
    import dic_pkg::*;
(
    // Clock
    input  wire logic              i_clk_sys,
    // Requested contact positions and chatter enable
    input  wire logic [NUM_IN-1:0] i_close,
    input  wire logic              i_bounce,
    // Energized pin levels
    output logic      [NUM_IN-1:0] o_energized
);
    logic [NUM_IN-1:0] last_q = '0;
    logic [NUM_IN-1:0] move_q = '0;
    int                chat_n = 0;
    // A moving contact chatters for a few cycles, so the pin is not clean at once.
    always @(posedge i_clk_sys)
    begin
        if (i_close != last_q && i_bounce)
        begin
            chat_n = 8;
            move_q = i_close ^ last_q;
        end
        last_q = i_close;
        if (chat_n > 0)
        begin
            o_energized <= o_energized ^ move_q;
            chat_n--;
        end
        else
            o_energized <= i_close;
    end
    initial o_energized = '0;
endmodule
`default_nettype wire

// ---- tb_digital_input_conditioner.sv ----
// Testbench comparing the conditioner with a scan-level model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_digital_input_conditioner;
    import dic_pkg::*;
    localparam int NSCAN = 30;
    // A 40-clock millisecond step keeps the run short; a scan stays five steps.
    localparam int STEP_T = 40;
    localparam int SCAN_T = STEP_T * STEPS_PER_SCAN;
    logic clk = 0, rst_n = 0, bounce = 0, tick;
    logic [NUM_IN-1:0] close = 0, pins, pol = 0, ac = 0;
    logic [NUM_IN*DLY_W-1:0] act = 0, drop = 0;
    logic [NUM_IN-1:0] raw, stat, lgc, outp;
    logic [NUM_IN-1:0] raw_m = 0, st_m = 0, stat_m = 0, lg_m = 0, out_m = 0;
    logic [NUM_IN-1:0] up, acd, cnl;
    int el[NUM_IN];
    int seed = 32'he1a0;
    int n_mismatch = 0, num_checks = 0, cyc = 0, last_tick = 0;
    // Delays avoid multiples of 5 ms plus 4, where the tick phase makes the scan ambiguous.
    int dly_tab[10] = '{0, 1, 2, 3, 6, 7, 8, 11, 12, 13};

    dic_contacts u_contacts (.i_clk_sys(clk), .i_close(close), .i_bounce(bounce),
        .o_energized(pins));
    dic_top #(.TICK_CYC(STEP_T)) dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_binary_input_n(pins),
        .i_polarity_nc(pol), .i_ac_mode(ac), .i_act_delay_ms(act),
        .i_drop_delay_ms(drop), .o_raw_state(raw), .o_status(stat),
        .o_logic_state(lgc), .o_binary_output_n(outp), .o_scan_tick(tick));

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > (NSCAN + 3) * SCAN_T)
        begin
            n_mismatch++;
            final_report;
        end
    end

    // ********************************
    // Model of one scan interval
    // ********************************
    task automatic model_step;
        int dd;
        up = 0;
        acd = 0;
        cnl = 0;
        for (int g = 0; g < NUM_IN; g++)
        begin
            dd = raw_m[g] ? act[g*DLY_W+:DLY_W] : drop[g*DLY_W+:DLY_W] + (ac[g] ? 30 : 0);
            if (raw_m[g] != st_m[g])
            begin
                el[g] += 5;
                if (el[g] > dd)
                begin
                    st_m[g] = raw_m[g];
                    up[g] = raw_m[g];
                    acd[g] = ~raw_m[g] & ac[g];
                    el[g] = 0;
                end
            end
            else
            begin
                cnl[g] = el[g] > 0;
                el[g] = 0;
            end
        end
        out_m = lg_m;
        lg_m = stat_m;
        stat_m = st_m;
        raw_m = pins ^ pol;
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        for (int g = 0; g < NUM_IN; g++)
        begin
            el[g] = 0;
            pol[g] = $random(seed);
            ac[g] = $random(seed);
            act[g*DLY_W+:DLY_W] = DLY_W'(dly_tab[$unsigned($random(seed)) % 10]);
            drop[g*DLY_W+:DLY_W] = DLY_W'(dly_tab[$unsigned($random(seed)) % 10]);
        end
        repeat (10) @(posedge clk);
        #2;
        `CHK("reset_out", 8'h00, stat | lgc | outp | raw)
        rst_n = 1;
        $display("test reset done");
        repeat (NSCAN)
        begin
            @(posedge clk iff tick === 1'b1);
            #1;
            if (last_tick != 0)
                `CHK("scan_period", SCAN_T, cyc - last_tick)
            last_tick = cyc;
            repeat (3) @(posedge clk);
            #2;
            model_step;
            `CHK("raw", raw_m, raw)
            `CHK("status_up", stat_m & up, stat & up)
            `CHK("status", stat_m, stat)
            `CHK("status_ac", stat_m & acd, stat & acd)
            `CHK("status_cancel", stat_m & cnl, stat & cnl)
            `CHK("logic", lg_m, lgc)
            `CHK("output", out_m, outp)
            close = close ^ NUM_IN'($random(seed));
            bounce = $random(seed);
        end
        $display("test scan_run done");
        final_report;
    end
endmodule
`default_nettype wire
